// [rtl/vpwm_amp_defs.vh]
/*
 * Constants for the voltage-mode PWM amplitude block: register byte
 * offsets, field positions, reset values and fixed figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef VPWM_AMP_DEFS_VH
`define VPWM_AMP_DEFS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_AMPL 8'h04
`define REG_THRS 8'h08
`define REG_STEP_INTERVAL_COUNT 8'h0c
`define REG_STATE 8'h10

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_AUTO_BIT 1
`define CTRL_MRES_LSB 4
`define CTRL_MRES_MSB 7

// Amplitude register fields
`define AMPL_OFS_LSB 0
`define AMPL_OFS_MSB 7
`define AMPL_GRAD_LSB 8
`define AMPL_GRAD_MSB 15

// State register fields
`define STATE_SCALE_MSB 7
`define STATE_VMODE_BIT 8
`define STATE_OLA_BIT 9
`define STATE_OLB_BIT 10

// Reset values
`define RST_CTRL 8'h00
`define RST_OFS 8'h80
`define RST_GRAD 8'h04
`define RST_THRS 20'h0_0000
`define RST_SCALE 8'h00

// Fixed figures
`define SINE_PEAK 9'h0f8
`define SCALE_MAX 8'hff
`define MICRO_FULL 9'h100
`define MRES_MAX 4'h8
`define OL_WINDOW 4

`endif

// [rtl/step_interval_timer.v]
/*
 * Measures the time between two step pulses in clock cycles and
 * normalises it to the 256-microstep equivalent.
 * Assumes step_i is a one-cycle pulse synchronous to clk_i.
 */
`timescale 1ns/1ps
module step_interval_timer #(
    parameter W = 20
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Step input and resolution
    input wire step_i,
    input wire [3:0] mres_i,
    // Normalised interval
    output reg [W-1:0] interval_o
);
    localparam RW = W + 8;
    reg [RW-1:0] raw_ff;
    wire [RW-1:0] norm = raw_ff >> mres_i;
    wire [W-1:0] norm_sat = (|norm[RW-1:W]) ? {W{1'b1}} : norm[W-1:0];

    always @(posedge clk_i) begin
        if (rst_i) begin
            raw_ff <= {RW{1'b0}};
            interval_o <= {W{1'b1}};
        end else begin
            if (step_i) begin
                raw_ff <= {{(RW-1){1'b0}}, 1'b1};
                interval_o <= norm_sat;
            end else begin
                if (~&raw_ff) begin
                    raw_ff <= raw_ff + {{(RW-1){1'b0}}, 1'b1};
                end
                // Slowing down shows before the next step arrives
                if (norm_sat > interval_o) begin
                    interval_o <= norm_sat;
                end
            end
        end
    end
endmodule

// [rtl/amp_divider.v]
/*
 * Serial restoring divider, one quotient bit per clock.
 * Assumes start_i is only raised while busy_o is low.
 */
`timescale 1ns/1ps
module amp_divider #(
    parameter NW = 16,
    parameter DW = 20
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Request
    input wire start_i,
    input wire [NW-1:0] num_i,
    input wire [DW-1:0] den_i,
    // Answer
    output reg busy_o,
    output reg done_o,
    output reg [NW-1:0] quo_o
);
    reg [DW:0] rem_ff;
    reg [DW-1:0] den_ff;
    reg [4:0] cnt_ff;
    wire [DW:0] trial = {rem_ff[DW-1:0], quo_o[NW-1]};
    wire ge = trial >= {1'b0, den_ff};

    always @(posedge clk_i) begin
        if (rst_i) begin
            rem_ff <= {(DW+1){1'b0}};
            den_ff <= {DW{1'b0}};
            cnt_ff <= 5'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            quo_o <= {NW{1'b0}};
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                rem_ff <= {(DW+1){1'b0}};
                // Zero divisor treated as one
                den_ff <= (den_i == {DW{1'b0}}) ? {{(DW-1){1'b0}}, 1'b1} : den_i;
                quo_o <= num_i;
                cnt_ff <= NW[4:0];
                busy_o <= 1'b1;
            end else if (busy_o) begin
                quo_o <= {quo_o[NW-2:0], ge};
                rem_ff <= ge ? (trial - {1'b0, den_ff}) : trial;
                cnt_ff <= cnt_ff - 5'h01;
                if (cnt_ff == 5'h01) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule

// [rtl/vpwm_amp.v]
/*
 * Voltage-mode PWM amplitude control: velocity based or regulated
 * amplitude, chopper hand-over by step interval, open-load flags,
 * and a classic Wishbone register slave.
 * Assumes step, sine and coil current inputs synchronous to clk_i.
 */
// Added by the designer: register access over Wishbone and the register offsets.
// Summary of operation
// - Amplitude follows measured step interval in clocks; no current needed.
// - Without autoscale, amplitude is offset plus gradient times 256 times fstep/fclk.
// - Step rate is normalised to the 256-microstep equivalent.
// - Amplitude scales an 8-bit sine of peak 248, divided by 256.
// - Voltage mode below the velocity threshold, current chopper above.
// - Threshold zero keeps voltage mode at every velocity.
// - Last amplitude is held in current mode; resumed afterward only with autoscale.
// - With autoscale, offset limits the amplitude on voltage-mode re-entry.
// - Per-coil open-load flag shows whether nominal current was reached.
// - Flags set if target current not reached in last few full steps.
// - A broken coil holds its open-load flag steadily on in voltage mode; outside voltage mode the flag is cleared.
// - With autoscale, amplitude is regulated from measured coil current.
// - Threshold is a 20-bit step interval; voltage mode while interval exceeds it.
// - Offset and gradient take 0 to 255; amplitude reads back 8-bit.
`timescale 1ns/1ps
`include "vpwm_amp_defs.vh"
module vpwm_amp #(
    parameter TW = 20,
    parameter OLW = `OL_WINDOW
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Step input
    input wire step_i,
    // Sine table values for both coils
    input wire signed [8:0] sine_a_i,
    input wire signed [8:0] sine_b_i,
    // Coil current measurement during on time
    input wire cur_sample_i,
    input wire [7:0] cur_a_i,
    input wire [7:0] cur_b_i,
    input wire [7:0] cur_target_i,
    // Coil drive and status
    output reg signed [8:0] coil_a_drive_o,
    output reg signed [8:0] coil_b_drive_o,
    output reg [7:0] pwm_scale_o,
    output reg voltage_mode_o,
    output reg open_load_coil_a_o,
    output reg open_load_coil_b_o
);
    localparam ST_OFF = 3'b001;
    localparam ST_VOLT = 3'b010;
    localparam ST_CURR = 3'b100;

    // Saturating 8-bit add
    function [7:0] sat_add;
        input [7:0] a;
        input [15:0] b;
        reg [16:0] s;
        begin
            s = {9'h000, a} + {1'b0, b};
            sat_add = (|s[16:8]) ? `SCALE_MAX : s[7:0];
        end
    endfunction

    // Clamp sine input to the table peak
    function signed [8:0] clamp_sine;
        input signed [8:0] v;
        begin
            if (v > $signed(`SINE_PEAK)) begin
                clamp_sine = $signed(`SINE_PEAK);
            end else if (v < -$signed(`SINE_PEAK)) begin
                clamp_sine = -$signed(`SINE_PEAK);
            end else begin
                clamp_sine = v;
            end
        end
    endfunction

    // Software settings
    reg en_ff;
    reg auto_ff;
    reg [3:0] mres_ff;
    reg [7:0] amplitude_offset_ff;
    reg [7:0] amplitude_gradient_ff;
    reg [TW-1:0] voltage_mode_velocity_threshold_ff;

    // Block state
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [7:0] scale_ff;
    reg [7:0] nxt_scale;
    reg [7:0] vel_amp_ff;
    reg [8:0] micro_acc_ff;
    reg [OLW-1:0] hist_a_ff;
    reg [OLW-1:0] hist_b_ff;
    reg reach_a_ff;
    reg reach_b_ff;

    wire [TW-1:0] step_interval_count;
    wire div_busy;
    wire div_done;
    wire [15:0] div_quo;

    // Interval between steps, normalised to 256 microsteps
    step_interval_timer #(
        .W(TW)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(step_i),
        .mres_i(mres_ff),
        .interval_o(step_interval_count)
    );

    // Gradient * 256 / interval equals gradient * 256 * fstep / fclk
    amp_divider #(
        .NW(16),
        .DW(TW)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(~div_busy),
        .num_i({amplitude_gradient_ff, 8'h00}),
        .den_i(step_interval_count),
        .busy_o(div_busy),
        .done_o(div_done),
        .quo_o(div_quo)
    );

    // Velocity based amplitude
    always @(posedge clk_i) begin
        if (rst_i) begin
            vel_amp_ff <= `RST_SCALE;
        end else if (div_done) begin
            vel_amp_ff <= sat_add(amplitude_offset_ff, div_quo);
        end
    end

    // Chopper selection by step interval
    wire slow = (voltage_mode_velocity_threshold_ff == {TW{1'b0}}) ||
                (step_interval_count > voltage_mode_velocity_threshold_ff);

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (en_ff) begin
                    nxt_state = slow ? ST_VOLT : ST_CURR;
                end
            end
            ST_VOLT: begin
                if (!en_ff) begin
                    nxt_state = ST_OFF;
                end else if (!slow) begin
                    nxt_state = ST_CURR;
                end
            end
            ST_CURR: begin
                if (!en_ff) begin
                    nxt_state = ST_OFF;
                end else if (slow) begin
                    nxt_state = ST_VOLT;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    wire hit_a = cur_sample_i && (cur_a_i >= cur_target_i);
    wire hit_b = cur_sample_i && (cur_b_i >= cur_target_i);

    // Amplitude update
    always @* begin
        nxt_scale = scale_ff;
        case (state_ff)
            ST_VOLT: begin
                if (!auto_ff) begin
                    nxt_scale = vel_amp_ff;
                end else if (cur_sample_i) begin
                    if (!hit_a || !hit_b) begin
                        nxt_scale = sat_add(scale_ff, {8'h00, amplitude_gradient_ff});
                    end else if (scale_ff != 8'h00) begin
                        nxt_scale = scale_ff - 8'h01;
                    end
                end
            end
            ST_CURR: begin
                if (nxt_state == ST_VOLT && auto_ff && scale_ff > amplitude_offset_ff) begin
                    nxt_scale = amplitude_offset_ff;
                end else begin
                    nxt_scale = scale_ff;
                end
            end
            default: begin
                nxt_scale = scale_ff;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_OFF;
            scale_ff <= `RST_SCALE;
        end else begin
            state_ff <= nxt_state;
            scale_ff <= nxt_scale;
        end
    end

    // Full step detection in 256-microstep units
    wire [8:0] micro_inc = `MICRO_FULL >> (8 - mres_ff);
    wire [9:0] micro_sum = {1'b0, micro_acc_ff} + {1'b0, micro_inc};
    wire full_step = step_i && micro_sum[8];

    always @(posedge clk_i) begin
        if (rst_i) begin
            micro_acc_ff <= 9'h000;
        end else if (step_i) begin
            micro_acc_ff <= {1'b0, micro_sum[7:0]};
        end
    end

    // Open-load history over the last few full steps
    always @(posedge clk_i) begin
        if (rst_i || state_ff != ST_VOLT) begin
            hist_a_ff <= {OLW{1'b1}};
            hist_b_ff <= {OLW{1'b1}};
            reach_a_ff <= 1'b0;
            reach_b_ff <= 1'b0;
        end else if (full_step) begin
            hist_a_ff <= {hist_a_ff[OLW-2:0], reach_a_ff | hit_a};
            hist_b_ff <= {hist_b_ff[OLW-2:0], reach_b_ff | hit_b};
            reach_a_ff <= 1'b0;
            reach_b_ff <= 1'b0;
        end else begin
            reach_a_ff <= reach_a_ff | hit_a;
            reach_b_ff <= reach_b_ff | hit_b;
        end
    end

    // Coil drive and status outputs
    wire signed [17:0] prod_a = clamp_sine(sine_a_i) * $signed({1'b0, scale_ff});
    wire signed [17:0] prod_b = clamp_sine(sine_b_i) * $signed({1'b0, scale_ff});

    always @(posedge clk_i) begin
        if (rst_i) begin
            coil_a_drive_o <= 9'h000;
            coil_b_drive_o <= 9'h000;
            pwm_scale_o <= `RST_SCALE;
            voltage_mode_o <= 1'b0;
            open_load_coil_a_o <= 1'b0;
            open_load_coil_b_o <= 1'b0;
        end else begin
            if (state_ff == ST_VOLT) begin
                coil_a_drive_o <= prod_a[16:8];
                coil_b_drive_o <= prod_b[16:8];
            end else begin
                coil_a_drive_o <= 9'h000;
                coil_b_drive_o <= 9'h000;
            end
            pwm_scale_o <= scale_ff;
            voltage_mode_o <= (state_ff == ST_VOLT);
            // No success in the whole window holds the flag on
            open_load_coil_a_o <= ~|hist_a_ff;
            open_load_coil_b_o <= ~|hist_b_ff;
        end
    end

    // Wishbone slave, answer one cycle after the request
    wire req = wb_cyc_i && wb_stb_i;
    wire wr = req && wb_we_i && wb_ack_o;

    always @(posedge clk_i) begin
        if (rst_i) begin
            en_ff <= |(`RST_CTRL & (8'h01 << `CTRL_EN_BIT));
            auto_ff <= |(`RST_CTRL & (8'h01 << `CTRL_AUTO_BIT));
            mres_ff <= 4'h0;
            amplitude_offset_ff <= `RST_OFS;
            amplitude_gradient_ff <= `RST_GRAD;
            voltage_mode_velocity_threshold_ff <= `RST_THRS;
        end else if (wr) begin
            case (wb_adr_i)
                `REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        en_ff <= wb_dat_i[`CTRL_EN_BIT];
                        auto_ff <= wb_dat_i[`CTRL_AUTO_BIT];
                        if (wb_dat_i[`CTRL_MRES_MSB:`CTRL_MRES_LSB] > `MRES_MAX) begin
                            mres_ff <= `MRES_MAX;
                        end else begin
                            mres_ff <= wb_dat_i[`CTRL_MRES_MSB:`CTRL_MRES_LSB];
                        end
                    end
                end
                `REG_AMPL: begin
                    if (wb_sel_i[0]) begin
                        amplitude_offset_ff <= wb_dat_i[`AMPL_OFS_MSB:`AMPL_OFS_LSB];
                    end
                    if (wb_sel_i[1]) begin
                        amplitude_gradient_ff <= wb_dat_i[`AMPL_GRAD_MSB:`AMPL_GRAD_LSB];
                    end
                end
                `REG_THRS: begin
                    if (wb_sel_i[0]) begin
                        voltage_mode_velocity_threshold_ff[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        voltage_mode_velocity_threshold_ff[15:8] <= wb_dat_i[15:8];
                    end
                    if (wb_sel_i[2]) begin
                        voltage_mode_velocity_threshold_ff[TW-1:16] <= wb_dat_i[TW-1:16];
                    end
                end
                default: begin
                    en_ff <= en_ff;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_ack_o && !wb_we_i) begin
                case (wb_adr_i)
                    `REG_CTRL: begin
                        wb_dat_o <= {24'h00_0000, mres_ff, 2'b00, auto_ff, en_ff};
                    end
                    `REG_AMPL: begin
                        wb_dat_o <= {16'h0000, amplitude_gradient_ff, amplitude_offset_ff};
                    end
                    `REG_THRS: begin
                        wb_dat_o <= {{(32-TW){1'b0}}, voltage_mode_velocity_threshold_ff};
                    end
                    `REG_STEP_INTERVAL_COUNT: begin
                        wb_dat_o <= {{(32-TW){1'b0}}, step_interval_count};
                    end
                    `REG_STATE: begin
                        wb_dat_o <= {21'h00_0000, open_load_coil_b_o, open_load_coil_a_o,
                                     voltage_mode_o, pwm_scale_o};
                    end
                    default: begin
                        wb_dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule

// [verification/vpwm_amp_properties.sv]
/*
 * Port checker for vpwm_amp: bus handshake, drive range and the
 * behaviour while the current chopper is selected.
 * Assumes the bind below and one clock with synchronous reset.
 */
`timescale 1ns/1ps
module vpwm_amp_properties #(
    parameter TW = 20,
    parameter OLW = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Drive and status
    input wire logic signed [8:0] coil_a_drive_o,
    input wire logic signed [8:0] coil_b_drive_o,
    input wire logic [7:0] pwm_scale_o,
    input wire logic voltage_mode_o,
    input wire logic open_load_coil_a_o,
    input wire logic open_load_coil_b_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence cur_mode3;
        !voltage_mode_o ##1 !voltage_mode_o ##1 !voltage_mode_o;
    endsequence
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_drive_off_current: assert property (cur_mode3 |-> $past(coil_a_drive_o) == 0 &&
        $past(coil_b_drive_o) == 0)
        else $error("coil drive outside voltage mode");
    a_flags_off_current: assert property (cur_mode3 |-> !$past(open_load_coil_a_o) &&
        !$past(open_load_coil_b_o))
        else $error("open-load flag outside voltage mode");
    a_scale_held: assert property (cur_mode3 |-> $stable(pwm_scale_o))
        else $error("scale moved in current mode");
    a_drive_in_range: assert property (coil_a_drive_o <= 247 && coil_a_drive_o >= -248 &&
        coil_b_drive_o <= 247 && coil_b_drive_o >= -248)
        else $error("coil drive beyond scaled sine peak");
    a_flag_rise_vmode: assert property ($rose(open_load_coil_a_o) |-> $past(voltage_mode_o))
        else $error("open-load flag rose outside voltage mode");
    c_ack: cover property (wb_ack_o);
    c_mode_fall: cover property ($fell(voltage_mode_o));
    c_mode_rise: cover property ($rose(voltage_mode_o));
    c_flag_a: cover property ($rose(open_load_coil_a_o));
endmodule
bind vpwm_amp vpwm_amp_properties #(.TW(TW), .OLW(OLW)) u_vpwm_amp_properties (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coil_a_drive_o(coil_a_drive_o),
    .coil_b_drive_o(coil_b_drive_o), .pwm_scale_o(pwm_scale_o),
    .voltage_mode_o(voltage_mode_o), .open_load_coil_a_o(open_load_coil_a_o),
    .open_load_coil_b_o(open_load_coil_b_o));

// [verification/coil_load.sv]
/*
 * Two-coil load: current follows the drive magnitude, sampled during
 * on time every 16 clocks; coil A can be broken open.
 * Assumes drive values synchronous to clk_i.
 */
`timescale 1ns/1ps
module coil_load (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Drive and fault
    input wire logic signed [8:0] coil_a_drive_i,
    input wire logic signed [8:0] coil_b_drive_i,
    input wire logic broken_a_i,
    // Measurement
    output logic cur_sample_o,
    output logic [7:0] cur_a_o,
    output logic [7:0] cur_b_o
);
    logic [3:0] tick_ff;
    function automatic logic [7:0] mag(input logic signed [8:0] v);
        mag = (v < 0) ? 8'(-v) : 8'(v);
    endfunction
    always @(posedge clk_i) begin
        tick_ff <= rst_i ? 4'h0 : tick_ff + 4'h1;
        cur_sample_o <= !rst_i && tick_ff == 4'hf;
        cur_a_o <= broken_a_i ? 8'h00 : mag(coil_a_drive_i);
        cur_b_o <= mag(coil_b_drive_i);
    end
endmodule

// [verification/tb_vpwm_amp.sv]
/*
 * Bench for vpwm_amp: Wishbone register tasks, a step generator and
 * a coil load model; checks amplitude, hand-over and flags.
 * Assumes a 100 MHz clock and synchronous reset.
 */
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: %s", $time, m); end end
module tb_vpwm_amp;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, step_i = 0;
    logic [7:0] wb_adr_i = 0, cur_a_i, cur_b_i, cur_target = 8'h0a;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic wb_ack_o, cur_sample_i, broken_a = 0, voltage_mode_o;
    logic open_load_coil_a_o, open_load_coil_b_o;
    logic signed [8:0] coil_a_drive_o, coil_b_drive_o;
    logic [7:0] pwm_scale_o;
    int bad_count = 0, checks_done = 0, step_per = 0, sc = 0, drops;
    vpwm_amp u_vpwm_amp (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_i(step_i),
        .sine_a_i(9'sd248), .sine_b_i(-9'sd248), .cur_sample_i(cur_sample_i),
        .cur_a_i(cur_a_i), .cur_b_i(cur_b_i), .cur_target_i(cur_target),
        .coil_a_drive_o(coil_a_drive_o), .coil_b_drive_o(coil_b_drive_o),
        .pwm_scale_o(pwm_scale_o), .voltage_mode_o(voltage_mode_o),
        .open_load_coil_a_o(open_load_coil_a_o), .open_load_coil_b_o(open_load_coil_b_o));
    coil_load u_coil_load (.clk_i(clk_i), .rst_i(rst_i), .coil_a_drive_i(coil_a_drive_o),
        .coil_b_drive_i(coil_b_drive_o), .broken_a_i(broken_a), .cur_sample_o(cur_sample_i),
        .cur_a_o(cur_a_i), .cur_b_o(cur_b_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Step pulses every step_per clocks
    always @(posedge clk_i) begin
        step_i <= step_per != 0 && sc == step_per - 1;
        sc <= (step_per == 0 || sc == step_per - 1) ? 0 : sc + 1;
    end
    task wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            wb_cyc_i <= 1;
            wb_stb_i <= 1;
            wb_we_i <= we;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_sel_i <= 4'hf;
            do begin
                @(posedge clk_i);
                n++;
            end while (wb_ack_o !== 1'b1 && n < 50);
            q = wb_dat_o;
            wb_cyc_i <= 0;
            wb_stb_i <= 0;
            wb_we_i <= 0;
            if (n >= 50) begin
                bad_count++;
                wrap_up();
            end
        end
    endtask
    task wait_mode(input logic v);
        int n;
        begin
            for (n = 0; n < 3000 && voltage_mode_o !== v; n++)
                @(posedge clk_i);
            if (n >= 3000) begin
                bad_count++;
                wrap_up();
            end
        end
    endtask
    function automatic logic [7:0] exp_scale(input int o, input int g, input int p);
        exp_scale = (o + g * 256 / p > 255) ? 8'hff : 8'(o + g * 256 / p);
    endfunction
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        `CHK(pwm_scale_o, 8'h00, "scale after reset")
        wb_xfer(0, 8'h04, 0);
        `CHK(q, 32'h0000_0480, "ampl reset value")
        wb_xfer(1, 8'h20, 32'hffff_ffff);
        wb_xfer(0, 8'h20, 0);
        `CHK(q, 32'h0000_0000, "unmapped read")
        $display("test reset done");
        wb_xfer(1, 8'h04, 32'h0000_1020);
        wb_xfer(1, 8'h00, 32'h0000_0001);
        step_per = 64;
        repeat (200) @(posedge clk_i);
        wb_xfer(0, 8'h10, 0);
        `CHK(q[7:0], exp_scale(32, 16, 64), "velocity amplitude")
        `CHK(q[8], 1'b1, "voltage mode with zero threshold")
        `CHK(coil_a_drive_o, 9'h05d, "drive a")
        `CHK(coil_b_drive_o, 9'h1a3, "drive b")
        wb_xfer(1, 8'h04, 32'h0000_04ff);
        step_per = 16;
        repeat (200) @(posedge clk_i);
        `CHK(pwm_scale_o, 8'hff, "saturated amplitude")
        wb_xfer(1, 8'h04, 32'h0000_0420);
        wb_xfer(1, 8'h00, 32'h0000_0021);
        step_per = 64;
        repeat (200) @(posedge clk_i);
        wb_xfer(0, 8'h0c, 0);
        `CHK(q[19:0], 20'h0_0010, "normalised interval")
        `CHK(pwm_scale_o, exp_scale(32, 4, 16), "normalised amplitude")
        $display("test velocity done");
        wb_xfer(1, 8'h04, 32'h0000_1020);
        wb_xfer(1, 8'h00, 32'h0000_0001);
        repeat (100) @(posedge clk_i);
        wb_xfer(1, 8'h08, 32'h0000_0064);
        wait_mode(0);
        wb_xfer(1, 8'h04, 32'h0000_0820);
        repeat (200) @(posedge clk_i);
        wb_xfer(0, 8'h10, 0);
        `CHK(q[8:0], 9'h060, "amplitude held in current mode")
        `CHK(coil_a_drive_o, 9'h000, "no drive in current mode")
        step_per = 128;
        wait_mode(1);
        repeat (200) @(posedge clk_i);
        `CHK(pwm_scale_o, exp_scale(32, 8, 128), "amplitude after re-entry")
        $display("test hand-over done");
        step_per = 0;
        repeat (100) @(posedge clk_i);
        cur_target <= 8'hf0;
        wb_xfer(1, 8'h04, 32'h0000_0498);
        wb_xfer(1, 8'h00, 32'h0000_0003);
        repeat (2100) @(posedge clk_i);
        `CHK(pwm_scale_o >= 8'hf7 && pwm_scale_o <= 8'hfb, 1'b1, "regulated amplitude")
        step_per = 32;
        wait_mode(0);
        step_per = 128;
        wait_mode(1);
        `CHK(pwm_scale_o, 8'h98, "re-entry limited by offset")
        $display("test re-entry done");
        broken_a = 1;
        wb_xfer(1, 8'h08, 32'h0000_0000);
        wb_xfer(1, 8'h04, 32'h0000_08ff);
        wb_xfer(1, 8'h00, 32'h0000_0083);
        repeat (1500) @(posedge clk_i);
        `CHK(open_load_coil_a_o, 1'b1, "broken coil flagged")
        `CHK(open_load_coil_b_o, 1'b0, "good coil not flagged")
        drops = 0;
        repeat (300) begin
            @(posedge clk_i);
            drops += (open_load_coil_a_o !== 1'b1);
        end
        `CHK(drops, 0, "broken coil flag steady")
        $display("test open-load done");
        wrap_up();
    end
endmodule
